/* verilog/modem_cmd_pkg.sv */
/*
  Constants, types and codes of the command-mode interpreter.
  Assumes a byte-wide receive and transmit path on one core clock.
*/
// Function
// - Indicator line: activity, high or low
// - Exit command leaves command mode at once
// - Flow line select accepts values 0 to 4
// - Strength query returns one byte 0x25-0x6a
// - Sixteen bit target address, default zero
// - Wake-up command forces preamble on next send
// - Channel range depends on hopping mode
// - Hardware revision is read only, two bytes
// - Sixteen bit address mask, default all ones
// - Restore returns settable values to defaults
// - Unit number read as two halves
// - Firmware revision is read only, two bytes
// - Values persist only after commit command
// - Values change any time in command mode
// - Empty parameter reads back stored value
// - Other parameters not settable by commands
// - Reply success or error after each command
// - Idle timeout leaves command mode
package modem_cmd_pkg;
  // ======
  // Settable configuration.
  typedef struct packed {
    logic [7:0]  ind_sel;   // Indicator line select.
    logic [7:0]  flow_sel;  // Flow line select.
    logic [15:0] target;    // Target address.
    logic [7:0]  channel;   // Channel select.
    logic [15:0] mask;      // Address space mask.
  } cfg_s;
  localparam cfg_s CFG_DEFAULT = '{8'h00, 8'h00, 16'h0000,
                                   8'h00, 16'hffff};
  // ======
  // States and reply kinds.
  typedef enum logic [2:0] {
    S_DATA = 3'b000, S_PLUS = 3'b001,
    S_CMD  = 3'b011, S_SEND = 3'b010
  } state_e;
  typedef enum logic [1:0] {K_OK, K_ERR, K_HEX2, K_HEX4} reply_e;
  // ======
  // Two-letter command codes in ASCII.
  localparam logic [15:0] CODE_IND  = 16'h4344;
  localparam logic [15:0] CODE_FLOW = 16'h4353;
  localparam logic [15:0] CODE_RSSI = 16'h4442;
  localparam logic [15:0] CODE_TGT  = 16'h4454;
  localparam logic [15:0] CODE_WAKE = 16'h4648;
  localparam logic [15:0] CODE_CHAN = 16'h4850;
  localparam logic [15:0] CODE_HWR  = 16'h4856;
  localparam logic [15:0] CODE_MASK = 16'h4d4b;
  localparam logic [15:0] CODE_REST = 16'h5245;
  localparam logic [15:0] CODE_UHI  = 16'h5348;
  localparam logic [15:0] CODE_ULO  = 16'h534c;
  localparam logic [15:0] CODE_FWR  = 16'h5652;
  localparam logic [15:0] CODE_EXIT = 16'h434e;
  localparam logic [15:0] CODE_SAVE = 16'h5752;
  // ======
  // Value limits and line encodings.
  localparam logic [7:0] IND_RX      = 8'h00;
  localparam logic [7:0] IND_HIGH    = 8'h01;
  localparam logic [7:0] IND_MAX     = 8'h02;
  localparam logic [7:0] FLOW_CTS    = 8'h00;
  localparam logic [7:0] FLOW_EN_LO  = 8'h01;
  localparam logic [7:0] FLOW_HIGH   = 8'h02;
  localparam logic [7:0] FLOW_EN_HI  = 8'h03;
  localparam logic [7:0] FLOW_MAX    = 8'h04;
  localparam logic [7:0] CHAN_HOP    = 8'h06;
  localparam logic [7:0] CHAN_SINGLE = 8'h18;
  localparam logic [7:0] RSSI_MIN    = 8'h25;
  localparam logic [7:0] RSSI_MAX    = 8'h6a;
  // ======
  // Characters.
  localparam logic [7:0] CH_A    = 8'h41;
  localparam logic [7:0] CH_T    = 8'h54;
  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_O    = 8'h4f;
  localparam logic [7:0] CH_K    = 8'h4b;
  localparam logic [7:0] CH_E    = 8'h45;
  localparam logic [7:0] CH_R    = 8'h52;
  localparam logic [1:0] PLUS_CNT = 2'h3;
  localparam logic [2:0] LEN_OK   = 3'h3;
  localparam logic [2:0] LEN_ERR  = 3'h6;
  localparam logic [2:0] LEN_HEX2 = 3'h3;
  localparam logic [2:0] LEN_HEX4 = 3'h5;
  // ======
  // Timing: 125 MHz core clock.
  localparam longint unsigned CLK_KHZ = 125000;
  localparam longint unsigned GUARD_MS = 1000;
  localparam longint unsigned TIMEOUT_MS = 20000;
  localparam longint unsigned GUARD_CYC = GUARD_MS * CLK_KHZ;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
endpackage

/* verilog/modem_cmd.sv */
/*
  Command-mode interpreter: detects the entry sequence, parses
  command lines, updates configuration and sends replies.
  Assumes deframed receive bytes and a transmit byte sink on
  CORE_CLK, and a non-volatile store that takes and gives back
  a configuration image.
*/
`timescale 1ns/1ns
module modem_cmd #(
  parameter logic [31:0] GUARD_CYC   = 32'(modem_cmd_pkg::GUARD_CYC),
  parameter logic [31:0] TIMEOUT_CYC =
    32'(modem_cmd_pkg::TIMEOUT_CYC),
  parameter logic [15:0] HW_REV  = 16'h0101, // Arbitrary value.
  parameter logic [15:0] FW_REV  = 16'h0202, // Arbitrary value.
  parameter logic [15:0] UNIT_HI = 16'h1234, // Arbitrary value.
  parameter logic [15:0] UNIT_LO = 16'h5678  // Arbitrary value.
) (
  input  wire logic               CORE_CLK,      // Core clock.
  input  wire logic               RST,           // Async reset.
  input  wire logic [7:0]         RX_DATA,       // Received byte.
  input  wire logic               RX_VALID,      // Byte strobe.
  output logic      [7:0]         TX_DATA,       // Reply byte.
  output logic                    TX_VALID,      // Reply valid.
  input  wire logic               TX_READY,      // Sink ready.
  input  wire logic               HOP_MODE,      // Hopping pin.
  input  wire logic               RX_ACTIVE,     // Rx activity.
  input  wire logic               TX_ACTIVE,     // Tx in progress.
  input  wire logic               CLEAR_N,       // Clear to send.
  input  wire logic [7:0]         RSSI_DATA,     // Packet strength.
  input  wire logic               RSSI_VALID,    // Strength strobe.
  input  wire logic               TX_START,      // Next send starts.
  input  wire logic               NV_LOAD_VALID, // Stored image in.
  input  wire modem_cmd_pkg::cfg_s NV_LOAD_CFG,  // Stored image.
  output logic                    NV_WRITE,      // Commit pulse.
  output modem_cmd_pkg::cfg_s     NV_CFG,        // Image to store.
  output modem_cmd_pkg::cfg_s     CFG,           // Live settings.
  output logic                    FORCE_WAKEUP,  // Send preamble.
  output logic                    CMD_MODE,      // In command mode.
  output logic                    INDICATOR_LINE, // Indicator pin.
  output logic                    FLOW_OUTPUT_LINE // Flow pin.
);
  // ======
  // State registers and their next values.
  modem_cmd_pkg::state_e state_reg, state_next; // Mode.
  modem_cmd_pkg::cfg_s   cfg_reg, cfg_next;     // Settings.
  modem_cmd_pkg::reply_e kind_reg, kind_next;   // Reply kind.
  logic [31:0] timer_reg, timer_next; // Silence or idle time.
  logic [1:0]  plus_reg, plus_next;   // Plus chars seen.
  logic [2:0]  pos_reg, pos_next;     // Line position.
  logic [15:0] code_reg, code_next;   // Command letters.
  logic [15:0] val_reg, val_next;     // Parameter value.
  logic [2:0]  ndig_reg, ndig_next;   // Digits taken.
  logic        bad_reg, bad_next;     // Line syntax error.
  logic [15:0] rval_reg, rval_next;   // Value to reply.
  logic [2:0]  idx_reg, idx_next;     // Reply char index.
  logic        exit_reg, exit_next;   // Leave after reply.
  logic        wake_reg, wake_next;   // Wake-up pending.
  logic [7:0]  rssi_reg, rssi_next;   // Last strength.
  logic [7:0]  txd_reg, txd_next;     // Reply byte.
  logic        txv_reg, txv_next;     // Reply valid.
  logic        nvw_reg, nvw_next;     // Commit pulse.
  logic        ind_reg, ind_next;     // Indicator pin.
  logic        flow_reg, flow_next;   // Flow pin.
  logic [1:0]  hop_sync;              // Pin synchroniser.
  logic [7:0]  ch;                    // Folded input char.
  logic [3:0]  nib;                   // Hex digit value.
  logic        is_hex;                // Char is hex digit.
  logic [2:0]  rlen;                  // Reply length.
  logic [7:0]  chan_max;              // Channel limit.

  // Hex digit to ASCII.
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'ha) ? (8'h30 + {4'h0, n})
                        : (8'h37 + {4'h0, n});
  endfunction

  // Reply character by kind and index.
  function automatic logic [7:0] reply_ch(
    input modem_cmd_pkg::reply_e k,
    input logic [2:0]  i,
    input logic [15:0] v);
    logic [7:0] c;
    c = modem_cmd_pkg::CH_CR;
    case (k)
      modem_cmd_pkg::K_OK: begin
        if (i == 3'h0) c = modem_cmd_pkg::CH_O;
        else if (i == 3'h1) c = modem_cmd_pkg::CH_K;
      end
      modem_cmd_pkg::K_ERR: begin
        case (i)
          3'h0: c = modem_cmd_pkg::CH_E;
          3'h3: c = modem_cmd_pkg::CH_O;
          3'h1, 3'h2, 3'h4: c = modem_cmd_pkg::CH_R;
          default: c = modem_cmd_pkg::CH_CR;
        endcase
      end
      modem_cmd_pkg::K_HEX2: begin
        if (i < 3'h2) c = hex_ch(v[4'(7 - 4 * i) -: 4]);
      end
      default: begin
        if (i < 3'h4) c = hex_ch(v[4'(15 - 4 * i) -: 4]);
      end
    endcase
    reply_ch = c;
  endfunction

  // ======
  // The hopping pin is a board level; two flops first.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      hop_sync <= 2'h0;
    end else begin
      hop_sync <= {hop_sync[0], HOP_MODE};
    end
  end

  // Fold lower case to upper and decode hex digits.
  always_comb begin
    ch = RX_DATA;
    if (RX_DATA >= 8'h61 && RX_DATA <= 8'h7a) ch = RX_DATA - 8'h20;
    is_hex = 1'b1;
    nib = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39) nib = ch[3:0];
    else if (ch >= 8'h41 && ch <= 8'h46) nib = ch[3:0] + 4'h9;
    else is_hex = 1'b0;
    chan_max = hop_sync[1] ? modem_cmd_pkg::CHAN_HOP
                           : modem_cmd_pkg::CHAN_SINGLE;
    case (kind_reg)
      modem_cmd_pkg::K_OK:   rlen = modem_cmd_pkg::LEN_OK;
      modem_cmd_pkg::K_ERR:  rlen = modem_cmd_pkg::LEN_ERR;
      modem_cmd_pkg::K_HEX2: rlen = modem_cmd_pkg::LEN_HEX2;
      default:               rlen = modem_cmd_pkg::LEN_HEX4;
    endcase
  end

  // ======
  // Main next-state logic: entry, parse, execute, reply.
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    kind_next = kind_reg;
    timer_next = (timer_reg == 32'hffffffff) ? timer_reg
                                             : timer_reg + 32'h1;
    plus_next = plus_reg;
    pos_next = pos_reg;
    code_next = code_reg;
    val_next = val_reg;
    ndig_next = ndig_reg;
    bad_next = bad_reg;
    rval_next = rval_reg;
    idx_next = idx_reg;
    exit_next = exit_reg;
    wake_next = wake_reg;
    rssi_next = rssi_reg;
    txd_next = txd_reg;
    txv_next = txv_reg;
    nvw_next = 1'b0;
    // Strength is clamped into its reporting range.
    if (RSSI_VALID) begin
      rssi_next = RSSI_DATA;
      if (RSSI_DATA < modem_cmd_pkg::RSSI_MIN)
        rssi_next = modem_cmd_pkg::RSSI_MIN;
      if (RSSI_DATA > modem_cmd_pkg::RSSI_MAX)
        rssi_next = modem_cmd_pkg::RSSI_MAX;
    end
    // A stored image replaces the live settings.
    if (NV_LOAD_VALID) cfg_next = NV_LOAD_CFG;
    // The wake request ends at the next send; set wins.
    if (TX_START) wake_next = 1'b0;
    case (state_reg)
      modem_cmd_pkg::S_DATA: begin
        // A plus after a full silence starts the entry.
        if (RX_VALID) begin
          timer_next = 32'h0;
          if (ch == modem_cmd_pkg::CH_PLUS && timer_reg >= GUARD_CYC)
          begin
            state_next = modem_cmd_pkg::S_PLUS;
            plus_next = 2'h1;
          end
        end
      end
      modem_cmd_pkg::S_PLUS: begin
        // Three pluses within the guard, then silence.
        if (RX_VALID) begin
          timer_next = 32'h0;
          if (ch == modem_cmd_pkg::CH_PLUS &&
              plus_reg != modem_cmd_pkg::PLUS_CNT) begin
            plus_next = plus_reg + 2'h1;
          end else begin
            state_next = modem_cmd_pkg::S_DATA;
          end
        end else if (timer_reg >= GUARD_CYC) begin
          timer_next = 32'h0;
          pos_next = 3'h0;
          ndig_next = 3'h0;
          bad_next = 1'b0;
          exit_next = 1'b0;
          state_next = (plus_reg == modem_cmd_pkg::PLUS_CNT)
                       ? modem_cmd_pkg::S_CMD : modem_cmd_pkg::S_DATA;
        end
      end
      modem_cmd_pkg::S_CMD: begin
        if (timer_reg >= TIMEOUT_CYC) begin
          state_next = modem_cmd_pkg::S_DATA;
          timer_next = 32'h0;
        end else if (RX_VALID && ch == modem_cmd_pkg::CH_CR) begin
          // Execute only once the line is complete.
          kind_next = modem_cmd_pkg::K_ERR;
          rval_next = 16'h0;
          if (pos_reg == 3'h2 && ndig_reg == 3'h0 && !bad_reg)
            kind_next = modem_cmd_pkg::K_OK;
          if (pos_reg == 3'h4 && !bad_reg) begin
            if (ndig_reg == 3'h0) begin
              // Empty field reads back the stored value.
              kind_next = modem_cmd_pkg::K_HEX2;
              case (code_reg)
                modem_cmd_pkg::CODE_IND:  rval_next = {8'h0, cfg_reg.ind_sel};
                modem_cmd_pkg::CODE_FLOW:
                  rval_next = {8'h0, cfg_reg.flow_sel};
                modem_cmd_pkg::CODE_CHAN:
                  rval_next = {8'h0, cfg_reg.channel};
                modem_cmd_pkg::CODE_RSSI:
                  rval_next = {8'h0, rssi_reg};
                default: kind_next = modem_cmd_pkg::K_HEX4;
              endcase
              case (code_reg)
                modem_cmd_pkg::CODE_TGT:  rval_next = cfg_reg.target;
                modem_cmd_pkg::CODE_MASK: rval_next = cfg_reg.mask;
                modem_cmd_pkg::CODE_HWR:  rval_next = HW_REV;
                modem_cmd_pkg::CODE_FWR:  rval_next = FW_REV;
                modem_cmd_pkg::CODE_UHI:  rval_next = UNIT_HI;
                modem_cmd_pkg::CODE_ULO:  rval_next = UNIT_LO;
                modem_cmd_pkg::CODE_EXIT: begin
                  kind_next = modem_cmd_pkg::K_OK;
                  exit_next = 1'b1;
                end
                modem_cmd_pkg::CODE_WAKE: begin
                  kind_next = modem_cmd_pkg::K_OK;
                  wake_next = 1'b1;
                end
                modem_cmd_pkg::CODE_REST: begin
                  kind_next = modem_cmd_pkg::K_OK;
                  cfg_next = modem_cmd_pkg::CFG_DEFAULT;
                end
                modem_cmd_pkg::CODE_SAVE: begin
                  kind_next = modem_cmd_pkg::K_OK;
                  nvw_next = 1'b1;
                end
                default: if (kind_next == modem_cmd_pkg::K_HEX4)
                  kind_next = modem_cmd_pkg::K_ERR;
              endcase
            end else begin
              // Writes take effect at once, range checked.
              kind_next = modem_cmd_pkg::K_OK;
              case (code_reg)
                modem_cmd_pkg::CODE_IND:
                  if (val_reg <= {8'h0, modem_cmd_pkg::IND_MAX})
                    cfg_next.ind_sel = val_reg[7:0];
                  else kind_next = modem_cmd_pkg::K_ERR;
                modem_cmd_pkg::CODE_FLOW:
                  if (val_reg <= {8'h0, modem_cmd_pkg::FLOW_MAX})
                    cfg_next.flow_sel = val_reg[7:0];
                  else kind_next = modem_cmd_pkg::K_ERR;
                modem_cmd_pkg::CODE_CHAN:
                  if (val_reg <= {8'h0, chan_max})
                    cfg_next.channel = val_reg[7:0];
                  else kind_next = modem_cmd_pkg::K_ERR;
                modem_cmd_pkg::CODE_TGT:
                  cfg_next.target = val_reg;
                modem_cmd_pkg::CODE_MASK:
                  cfg_next.mask = val_reg;
                // Read-only and unknown codes refuse.
                default: kind_next = modem_cmd_pkg::K_ERR;
              endcase
            end
          end
          // Every line gets a reply.
          state_next = modem_cmd_pkg::S_SEND;
          idx_next = 3'h0;
          txv_next = 1'b1;
          txd_next = reply_ch(kind_next, 3'h0, rval_next);
          timer_next = 32'h0;
          pos_next = 3'h0;
          ndig_next = 3'h0;
          bad_next = 1'b0;
        end else if (RX_VALID) begin
          // Collect the prefix, two letters, then hex digits.
          if (pos_reg == 3'h0) begin
            bad_next = bad_reg | (ch != modem_cmd_pkg::CH_A);
            pos_next = 3'h1;
          end else if (pos_reg == 3'h1) begin
            bad_next = bad_reg | (ch != modem_cmd_pkg::CH_T);
            pos_next = 3'h2;
          end else if (pos_reg < 3'h4) begin
            code_next = {code_reg[7:0], ch};
            pos_next = pos_reg + 3'h1;
            val_next = 16'h0;
          end else if (is_hex && ndig_reg < 3'h4) begin
            val_next = {val_reg[11:0], nib};
            ndig_next = ndig_reg + 3'h1;
          end else if (ch != 8'h20) begin
            bad_next = 1'b1;
          end
        end
      end
      modem_cmd_pkg::S_SEND: begin
        // Hold each byte until the sink takes it.
        if (TX_READY) begin
          if (idx_reg + 3'h1 == rlen) begin
            txv_next = 1'b0;
            state_next = exit_reg ? modem_cmd_pkg::S_DATA
                                  : modem_cmd_pkg::S_CMD;
            timer_next = 32'h0;
          end else begin
            idx_next = idx_reg + 3'h1;
            txd_next = reply_ch(kind_reg, idx_next, rval_reg);
          end
        end
      end
      default: state_next = modem_cmd_pkg::S_DATA;
    endcase
  end

  // Output line selection, registered.
  always_comb begin
    case (cfg_reg.ind_sel)
      modem_cmd_pkg::IND_RX:   ind_next = RX_ACTIVE;
      modem_cmd_pkg::IND_HIGH: ind_next = 1'b1;
      default:                 ind_next = 1'b0;
    endcase
    case (cfg_reg.flow_sel)
      modem_cmd_pkg::FLOW_CTS:   flow_next = CLEAR_N;
      modem_cmd_pkg::FLOW_EN_LO: flow_next = ~TX_ACTIVE;
      modem_cmd_pkg::FLOW_HIGH:  flow_next = 1'b1;
      modem_cmd_pkg::FLOW_EN_HI: flow_next = TX_ACTIVE;
      default:                   flow_next = 1'b0;
    endcase
  end

  // ======
  // Register everything; reset restores defaults.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= modem_cmd_pkg::S_DATA;
      cfg_reg <= modem_cmd_pkg::CFG_DEFAULT;
      kind_reg <= modem_cmd_pkg::K_OK;
      timer_reg <= 32'h0;
      plus_reg <= 2'h0;
      pos_reg <= 3'h0;
      code_reg <= 16'h0;
      val_reg <= 16'h0;
      ndig_reg <= 3'h0;
      bad_reg <= 1'b0;
      rval_reg <= 16'h0;
      idx_reg <= 3'h0;
      exit_reg <= 1'b0;
      wake_reg <= 1'b0;
      rssi_reg <= modem_cmd_pkg::RSSI_MIN;
      txd_reg <= 8'h00;
      txv_reg <= 1'b0;
      nvw_reg <= 1'b0;
      ind_reg <= 1'b0;
      flow_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      kind_reg <= kind_next;
      timer_reg <= timer_next;
      plus_reg <= plus_next;
      pos_reg <= pos_next;
      code_reg <= code_next;
      val_reg <= val_next;
      ndig_reg <= ndig_next;
      bad_reg <= bad_next;
      rval_reg <= rval_next;
      idx_reg <= idx_next;
      exit_reg <= exit_next;
      wake_reg <= wake_next;
      rssi_reg <= rssi_next;
      txd_reg <= txd_next;
      txv_reg <= txv_next;
      nvw_reg <= nvw_next;
      ind_reg <= ind_next;
      flow_reg <= flow_next;
    end
  end

  assign TX_DATA = txd_reg;
  assign TX_VALID = txv_reg;
  assign NV_WRITE = nvw_reg;
  assign NV_CFG = cfg_reg;
  assign CFG = cfg_reg;
  assign FORCE_WAKEUP = wake_reg;
  // Exit drops the mode flag while its reply drains.
  assign CMD_MODE = (state_reg == modem_cmd_pkg::S_CMD) ||
                    (state_reg == modem_cmd_pkg::S_SEND && !exit_reg);
  assign INDICATOR_LINE = ind_reg;
  assign FLOW_OUTPUT_LINE = flow_reg;
endmodule

/* verif/modem_host.sv */
/* Host model: sends command lines byte by byte, gathers replies.
   Assumes the byte link of modem_cmd on one core clock. */
`timescale 1ns/1ns
module modem_host (
  input  wire logic       clk,      // Core clock.
  output logic      [7:0] rx_data,  // Byte to the device.
  output logic            rx_valid, // Byte strobe.
  input  wire logic [7:0] tx_data,  // Reply byte.
  input  wire logic       tx_valid, // Reply valid.
  output logic            tx_ready  // Reply sink ready.
);
  // ======
  // Link driver at the device's own rate and framing.
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Ready toggles, so the sink is ready every other cycle and each later reply byte stalls one cycle.
  always @(negedge clk) tx_ready <= ~tx_ready;
  // One byte every two cycles; an idle bus never shows the old byte.
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx_data  = b;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_data  = ~b;
    rx_valid = 1'b0;
  endtask
  // Silence, three pluses, then silence again.
  task automatic enter(input int g);
    repeat (g + 4) @(negedge clk);
    repeat (3) put(8'h2b);
    repeat (g + 4) @(negedge clk);
  endtask
  // Line ends in a carriage return; gathering is bounded.
  task automatic line(input logic [15:0] c, input string a,
                      output logic [63:0] r);
    string s;
    s = $sformatf("AT%s%s", c, a);
    r = '0;
    foreach (s[i]) put(s[i]);
    put(8'h0d);
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (tx_valid && tx_ready) r = {r[55:0], tx_data};
      if (r[7:0] === 8'h0d) break;
    end
  endtask
endmodule

/* verif/modem_cmd_chk.sv */
/* Port checker of the command interpreter.
   Assumes it is bound into modem_cmd; one clock, RST active high. */
`timescale 1ns/1ns
module modem_cmd_chk (
  input wire logic                CORE_CLK,       // Clock.
  input wire logic                RST,            // Reset.
  input wire logic [7:0]          RX_DATA,        // Rx byte.
  input wire logic                RX_VALID,       // Rx strobe.
  input wire logic [7:0]          TX_DATA,        // Tx byte.
  input wire logic                TX_VALID,       // Tx valid.
  input wire logic                TX_READY,       // Tx ready.
  input wire logic                RX_ACTIVE,      // Rx activity.
  input wire logic                TX_START,       // Send starts.
  input wire logic                NV_LOAD_VALID,  // Image load.
  input wire logic                NV_WRITE,       // Commit.
  input wire modem_cmd_pkg::cfg_s NV_CFG,         // Stored image.
  input wire modem_cmd_pkg::cfg_s CFG,            // Live values.
  input wire logic                FORCE_WAKEUP,   // Wake flag.
  input wire logic                CMD_MODE,       // Command mode.
  input wire logic                INDICATOR_LINE  // Indicator pin.
);
  // ======
  // Checks run on the core clock and rest while reset is high.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Line end taken in command mode with no reply pending.
  sequence s_line_end;
    RX_VALID && RX_DATA == 8'h0d && CMD_MODE && !TX_VALID;
  endsequence
  a_reply_start: assert property (s_line_end |=> TX_VALID)
    else $error("no reply after line end");
  a_reply_hold: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte changed while stalled");
  a_ind_follow: assert property (
    CFG.ind_sel == 8'h00 |=> INDICATOR_LINE == $past(RX_ACTIVE))
    else $error("indicator does not follow activity");
  a_ind_fixed: assert property (
    CFG.ind_sel inside {8'h01, 8'h02} |=>
    INDICATOR_LINE == ($past(CFG.ind_sel) == 8'h01))
    else $error("indicator fixed level wrong");
  a_value_range: assert property (
    CFG.ind_sel <= 8'h02 && CFG.flow_sel <= 8'h04 &&
    CFG.channel <= 8'h18) else $error("setting out of range");
  a_commit_pulse: assert property (NV_WRITE |=> !NV_WRITE)
    else $error("commit pulse too long");
  a_commit_image: assert property (
    NV_WRITE |-> NV_CFG == CFG && TX_VALID && CMD_MODE)
    else $error("commit image differs");
  a_cfg_frozen: assert property (
    !CMD_MODE && !NV_LOAD_VALID |=> $stable(CFG))
    else $error("settings changed outside command mode");
  a_wake_hold: assert property (
    FORCE_WAKEUP && !TX_START |=> FORCE_WAKEUP)
    else $error("wake flag lost before send");
endmodule

/* verif/modem_cmd_tb.sv */
/* Bench of modem_cmd: host model, checker and scenarios.
   Assumes a 125 MHz clock and shortened guard and timeout counts. */
`timescale 1ns/1ns
module modem_cmd_tb;
  // ======
  // Signals; short guard (20) and timeout (200) counts.
  logic                core_clk = 1'b0;  // Core clock.
  logic                rst = 1'b1;       // Reset.
  logic                rx_act = 1'b0;    // Receive activity.
  logic                hop = 1'b1, tx_act = 1'b0; // Pin levels.
  logic                rssi_v = 1'b0;    // Strength strobe.
  logic                tx_start = 1'b0;  // Send start.
  logic [7:0]          rssi = 8'h00;     // Strength value.
  logic [7:0]          rx_data, tx_data; // Byte link data.
  logic                rx_valid, tx_valid, tx_ready, nv_write;
  logic                wake, cmd_mode, ind_line, flow_line;
  modem_cmd_pkg::cfg_s nv_cfg, cfg;      // Settings images.
  logic [63:0]         r;                // Gathered reply.
  int                  n_fail = 0, num_checks = 0, n_wr = 0;
  always #4 core_clk = ~core_clk;
  always @(negedge core_clk) rx_act <= ~rx_act;
  always @(posedge core_clk) if (nv_write === 1'b1) n_wr++;
  modem_host host (.clk(core_clk), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  modem_cmd #(.GUARD_CYC(32'd20), .TIMEOUT_CYC(32'd200)) dut (
    .CORE_CLK(core_clk), .RST(rst), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .HOP_MODE(hop), .RX_ACTIVE(rx_act),
    .TX_ACTIVE(tx_act), .CLEAR_N(1'b1), .RSSI_DATA(rssi),
    .RSSI_VALID(rssi_v), .TX_START(tx_start), .NV_LOAD_VALID(1'b0),
    .NV_LOAD_CFG(modem_cmd_pkg::CFG_DEFAULT), .NV_WRITE(nv_write),
    .NV_CFG(nv_cfg), .CFG(cfg), .FORCE_WAKEUP(wake),
    .CMD_MODE(cmd_mode), .INDICATOR_LINE(ind_line),
    .FLOW_OUTPUT_LINE(flow_line));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One command line; a reply that never ends closes the run.
  task automatic cmd(input logic [15:0] c, input string a,
                     input logic [55:0] e);
    host.line(c, a, r);
    @(negedge core_clk);
    cmp(r, {e, 8'h0d});
    if (r[7:0] !== 8'h0d) stop_test();
  endtask
  task automatic t_config();
    cmd(16'h4454, "1F", "OK");
    cmp(cfg.target, 64'h001f);
    cmd(16'h4454, "", "001F");
    cmd(16'h4d4b, "", "FFFF");
    cmd(16'h4850, "7", "ERROR");
    cmd(16'h4850, "6", "OK");
    hop = 1'b0;
    cmd(16'h4850, "18", "OK");
    cmd(16'h4353, "5", "ERROR");
    cmd(16'h4353, "3", "OK");
    cmp(flow_line, 64'h0);
    tx_act = 1'b1;
    @(negedge core_clk);
    cmp(flow_line, 64'h1);
    cmd(16'h4353, "", "03");
    cmd(16'h4344, "1", "OK");
    cmp(ind_line, 64'h1);
    cmd(16'h4344, "2", "OK");
    cmp(ind_line, 64'h0);
    cmd(16'h4249, "1", "ERROR");
  endtask
  task automatic t_ident();
    cmd(16'h4856, "", "0101");
    cmd(16'h4856, "1", "ERROR");
    cmd(16'h5652, "", "0202");
    cmd(16'h5348, "", "1234");
    cmd(16'h534c, "", "5678");
  endtask
  task automatic t_special();
    @(negedge core_clk);
    rssi   = 8'h40;
    rssi_v = 1'b1;
    @(negedge core_clk);
    rssi_v = 1'b0;
    cmd(16'h4442, "", "40");
    cmd(16'h4648, "", "OK");
    cmp(wake, 64'h1);
    tx_start = 1'b1;
    @(negedge core_clk);
    tx_start = 1'b0;
    @(negedge core_clk);
    cmp(wake, 64'h0);
    cmd(16'h5245, "", "OK");
    cmp(cfg, modem_cmd_pkg::CFG_DEFAULT);
    cmd(16'h5752, "", "OK");
    cmp(n_wr, 64'h1);
  endtask
  task automatic t_exit();
    cmd(16'h434e, "", "OK");
    cmp(cmd_mode, 64'h0);
    host.enter(20);
    cmp(cmd_mode, 64'h1);
    repeat (210) @(negedge core_clk);
    cmp(cmd_mode, 64'h0);
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    host.enter(20);
    cmp(cmd_mode, 64'h1);
    t_config();
    t_ident();
    t_special();
    t_exit();
    stop_test();
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
bind modem_cmd modem_cmd_chk chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_ACTIVE(RX_ACTIVE),
  .TX_START(TX_START), .NV_LOAD_VALID(NV_LOAD_VALID),
  .NV_WRITE(NV_WRITE), .NV_CFG(NV_CFG), .CFG(CFG),
  .FORCE_WAKEUP(FORCE_WAKEUP), .CMD_MODE(CMD_MODE),
  .INDICATOR_LINE(INDICATOR_LINE));
